// File: dv/pet_pin_model.sv
// pulse source standing in for the external event, capture and tooth-edge drivers
// assumes one-cycle requests from the bench; pins idle low between pulses
`timescale 1ns/10ps
module pet_pin_model #(
   parameter int HIGH_CYC = 6
) (
   input  wire logic       clk_i,
   input  wire logic [2:0] pulse_req_i,
   output logic [2:0]      pins_o
);
   int cnt [3];

   initial pins_o = 3'h0;

   // pulses stay wide enough to pass the three-stage synchroniser
   always @(posedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         if (pulse_req_i[i]) begin
            pins_o[i] <= 1'b1;
            cnt[i]    <= HIGH_CYC;
         end else if (cnt[i] > 1) begin
            cnt[i] <= cnt[i] - 1;
         end else begin
            pins_o[i] <= 1'b0;
         end
      end
   end
endmodule

// File: dv/tb_pet_timer.sv
// self-checking bench for the pwm / event / missing-teeth timer
// assumes the design takes one write strobe per cycle and syncs its pins
`timescale 1ns/10ps
module tb_pet_timer
   import pet_pkg::*;
;

   logic        clk_i     = 1'b0;
   logic        sys_rst_i = 1'b1;
   pet_config_t cfg       = '0;
   pet_cpu_wr_t cpu       = '0;
   logic [2:0]  req       = 3'h0;
   logic [2:0]  pins;
   logic        pwm_wave;
   pet_status_t st;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          hi;
   int          dma;

   always #4 clk_i = ~clk_i;

   pet_timer u_pet_timer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg), .cpu_wr_i(cpu),
      .event_pin_i(pins[0]), .capture_input_pin_i(pins[1]), .tooth_edge_input_i(pins[2]),
      .pwm_wave_o(pwm_wave), .status_o(st));
   pet_pin_model u_pet_pin_model (.clk_i(clk_i), .pulse_req_i(req), .pins_o(pins));

   task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // now=1 launches on the current falling edge, to hit a chosen count value
   task automatic wr(input pet_target_t t, input logic [15:0] d, input bit now = 1'b0);
      if (!now) @(negedge clk_i);
      cpu = '{1'b1, t, d};
      @(negedge clk_i);
      cpu.valid = 1'b0;
   endtask

   task automatic pulse(input int pin);
      @(negedge clk_i);
      req[pin] = 1'b1;
      @(negedge clk_i);
      req = 3'h0;
      wait_clk(20);
   endtask

   task automatic wait_val(input bit cap, input logic [15:0] v);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge clk_i);
         if ((cap ? st.capture_count : st.pwm_count) === v) break;
      end
      chk_bit("count reached", 1'b1, i < 400);
   endtask

   task automatic pwm_run(input logic [7:0] psc, input pet_div_t sel, input logic [15:0] buf_v);
      int k;
      k = (psc + 1) * (1 << sel);
      cfg.counter_start[0] = 1'b0;
      wr(PET_TGT_PWM_COUNT, 16'h0000);
      wr(PET_TGT_BUFFER, buf_v);
      cfg.prescaler_stage1_b = psc;
      cfg.pwm_clock_select = sel;
      wait_clk(32);
      cfg.counter_start[0] = 1'b1;
      wait_clk(3 * 8 * k);
      hi = 0;
      dma = 0;
      repeat (4 * 8 * k) begin
         @(negedge clk_i);
         hi += pwm_wave;
         dma += st.dma_req;
      end
      chk_word("high clocks", 16'(4 * buf_v * k), 16'(hi));
      chk_word("dma pulses", 16'h0004, 16'(dma));
      chk_word("duty", buf_v, st.duty);
      chk_bit("cycle irq", 1'b1, st.irq[FLG_CYCLE]);
   endtask

   task automatic summarize;
      $display("mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // the whole sequence needs well under 15000 clocks
   initial begin
      #(8 * 30000);
      error_cnt++;
      summarize();
   end

   initial begin
      wait_clk(4);
      sys_rst_i = 1'b0;
      chk_bit("status after reset", 1'b1, st === '0);
      chk_bit("wave after reset", 1'b0, pwm_wave);
      cfg.interrupt_enable = 4'h1;
      cfg.dma_enable = 1'b1;
      wr(PET_TGT_CYCLE, 16'h0008);
      pwm_run(8'h00, PET_DIV1, 16'h0003);
      pwm_run(8'h01, PET_DIV2, 16'h0005);
      pwm_run(8'h02, PET_DIV8, 16'h0005);
      pwm_run(8'h00, PET_DIV4, 16'h0000);
      pwm_run(8'h00, PET_DIV1, 16'h0008);
      wait_val(1'b0, 16'h0003);
      wr(PET_TGT_PWM_COUNT, 16'h0005, 1'b1);
      chk_word("write vs step", 16'h0005, st.pwm_count);
      wait_val(1'b0, 16'h0007);
      wr(PET_TGT_PWM_COUNT, 16'h0002, 1'b1);
      chk_word("write vs match clear", 16'h0002, st.pwm_count);
      wr(PET_TGT_CYCLE, 16'h0001);
      wr(PET_TGT_PWM_COUNT, 16'h0000);
      wr(PET_TGT_BUFFER, 16'h0001);
      wait_clk(4);
      chk_bit("flag read", 1'b1, st.flags[FLG_CYCLE]);
      wr(PET_TGT_FLAGS, 16'hFFFE);
      chk_bit("clear vs set", 1'b0, st.flags[FLG_CYCLE]);
      wr(PET_TGT_DUTY, 16'h0000);
      chk_word("duty write vs transfer", 16'h0000, st.duty);
      cfg.counter_start[0] = 1'b0;
      cfg.counter_start[1] = 1'b1;
      wr(PET_TGT_CAP_COUNT, 16'hFFF0);
      wait_val(1'b1, 16'hFFFF);
      wr(PET_TGT_CAP_COUNT, 16'h1234, 1'b1);
      chk_word("write vs wrap", 16'h1234, st.capture_count);
      chk_bit("overflow flag", 1'b1, st.flags[FLG_OVF]);
      cfg.counter_start[1] = 1'b0;
      wr(PET_TGT_EVENT_CMP, 16'hFFFF);
      for (int m = 0; m < 4; m++) begin
         cfg.event_edge_select = pet_edge_t'(m);
         wr(PET_TGT_EVENT_COUNT, 16'h0000);
         pulse(0);
         chk_word("edges counted", 16'(m == 0 ? 0 : (m == 3 ? 2 : 1)), st.event_count);
      end
      cfg.event_edge_select = PET_EDGE_RISE;
      cfg.capture_trigger_enable = 1'b1;
      cfg.interrupt_enable = 4'hF;
      wr(PET_TGT_FLAGS, 16'h0000);
      wr(PET_TGT_CAP_COUNT, 16'hABCD);
      wr(PET_TGT_EVENT_CMP, 16'h0003);
      wr(PET_TGT_EVENT_COUNT, 16'h0000);
      pulse(1);
      chk_word("masked capture pin", 16'h0000, st.capture_value);
      repeat (2) pulse(0);
      chk_word("events so far", 16'h0002, st.event_count);
      pulse(0);
      chk_word("event match clear", 16'h0000, st.event_count);
      chk_word("irq lines", 16'h0004, 16'(st.irq));
      chk_word("triggered capture", 16'hABCD, st.capture_value);
      wr(PET_TGT_CAP_COUNT, 16'h4321);
      cfg.capture_io_control = PET_EDGE_RISE;
      pulse(1);
      chk_word("pin capture", 16'h4321, st.capture_value);
      cfg.capture_io_control = PET_EDGE_NONE;
      cfg.tooth_compare_mode = 1'b1;
      cfg.edge_multiply_factor = 3'h2;
      cfg.reload_update_enable = 1'b1;
      cfg.clock_edge_select = PET_EDGE_RISE;
      wr(PET_TGT_TOOTH_CMP, 16'h0002);
      wait_clk(32);
      cfg.counter_start[2] = 1'b1;
      repeat (3) begin
         pulse(2);
         wait_clk(18);
      end
      chk_bit("reload scaled", 1'b1, st.tooth_reload >= 9 && st.tooth_reload <= 11);
      chk_bit("tooth match", 1'b1, st.flags[FLG_TOOTH]);
      wait_clk(200);
      chk_bit("multiplied count runs", 1'b1, st.tooth_count > 10);
      pulse(2);
      chk_bit("edge clears count", 1'b1, st.tooth_count < 4);
      cfg.counter_start[2] = 1'b0;
      cfg.reload_update_enable = 1'b0;
      wr(PET_TGT_TOOTH_RLD, 16'h0055);
      pulse(2);
      chk_word("reload held", 16'h0055, st.tooth_reload);
      summarize();
   end
endmodule

// File: rtl/pet_pkg.sv
// shared constants, types and carriers for the pwm / event / missing-teeth timer
// assumes one 125 MHz peripheral clock and plain configuration ports, no register bus
package pet_pkg;

   localparam int CNT_W = 16;
   localparam int PSC_W = 8;

   localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
   localparam logic [PSC_W-1:0] PSC_ONE    = 8'h01;
   localparam logic [2:0]       STAGE2_ONE = 3'h1;

   // status flag positions
   localparam int FLG_CYCLE = 0;
   localparam int FLG_OVF   = 1;
   localparam int FLG_EVENT = 2;
   localparam int FLG_TOOTH = 3;
   localparam int FLG_W     = 4;

   typedef enum logic [1:0] {
      PET_EDGE_NONE = 2'b00,
      PET_EDGE_RISE = 2'b01,
      PET_EDGE_FALL = 2'b10,
      PET_EDGE_BOTH = 2'b11
   } pet_edge_t;

   // second stage divide: 1, 2, 4 or 8 first-stage ticks
   typedef enum logic [1:0] {
      PET_DIV1 = 2'b00,
      PET_DIV2 = 2'b01,
      PET_DIV4 = 2'b10,
      PET_DIV8 = 2'b11
   } pet_div_t;

   typedef enum logic [3:0] {
      PET_TGT_PWM_COUNT   = 4'h0,
      PET_TGT_CYCLE       = 4'h1,
      PET_TGT_DUTY        = 4'h2,
      PET_TGT_BUFFER      = 4'h3,
      PET_TGT_EVENT_COUNT = 4'h4,
      PET_TGT_EVENT_CMP   = 4'h5,
      PET_TGT_CAP_COUNT   = 4'h6,
      PET_TGT_TOOTH_RLD   = 4'h7,
      PET_TGT_TOOTH_COUNT = 4'h8,
      PET_TGT_TOOTH_CMP   = 4'h9,
      PET_TGT_FLAGS       = 4'hA
   } pet_target_t;

   typedef struct packed {
      logic             valid;
      pet_target_t      target;
      logic [CNT_W-1:0] data;
   } pet_cpu_wr_t;

   typedef struct packed {
      logic [PSC_W-1:0] prescaler_stage1_b;
      logic [PSC_W-1:0] prescaler_stage1_c;
      logic [PSC_W-1:0] prescaler_stage1_d;
      pet_div_t         pwm_clock_select;
      pet_div_t         capture_clock_select;
      pet_div_t         tooth_clock_select;
      logic [2:0]       counter_start;
      logic [FLG_W-1:0] interrupt_enable;
      logic             dma_enable;
      pet_edge_t        event_edge_select;
      logic             capture_trigger_enable;
      pet_edge_t        capture_io_control;
      logic [2:0]       edge_multiply_factor;
      logic             reload_update_enable;
      pet_edge_t        clock_edge_select;
      logic             tooth_compare_mode;
   } pet_config_t;

   typedef struct packed {
      logic [FLG_W-1:0] irq;
      logic             dma_req;
      logic [FLG_W-1:0] flags;
      logic [CNT_W-1:0] pwm_count;
      logic [CNT_W-1:0] duty;
      logic [CNT_W-1:0] event_count;
      logic [CNT_W-1:0] capture_count;
      logic [CNT_W-1:0] capture_value;
      logic [CNT_W-1:0] tooth_reload;
      logic [CNT_W-1:0] tooth_count;
   } pet_status_t;

endpackage

// File: rtl/pet_timer.sv
// pwm channel with duty buffer, event counter with capture hand-off, missing-teeth counter
// assumes cpu writes arrive as one-cycle strobes and external pins are asynchronous
// How it works
// [R1] two prescaler stages form each channel's count clock
// [R2] cycle match drives pin 1, duty match 0
// [R3] cycle match raises interrupt and optional dma
// [R4] start bit lets the channel counter run
// [R5] cycle match copies buffer into duty
// [R6] software writes buffer, not duty, while running
// [R7] duty zero gives 0%, buffer=cycle gives 100%
// [R8] software keeps buffer not above cycle
// [R9] event counter counts edges, flags compare match
// [R10] edge select picks counted event edges
// [R11] event match triggers capture when enabled
// [R12] capture-disabled setting ignores the capture pin
// [R13] event match may interrupt; triggered capture never
// [R14] interval scaled by factor; reload needs enable
// [R15] multiplied clock counts; each edge clears counter
// [R16] tooth counter equal compare sets flag
// [R17] counter write beats compare-match clear
// [R18] counter write beats a count step
// [R19] counter write beats overflow wrap, flag set
// [R20] flag zero-write beats simultaneous flag set
// [R21] duty write beats buffer transfer
// [R22] software reads flag before clearing it
// [R23] software waits 32 clocks after prescaler setup
// [R24] pwm counter restarts after cycle match
`timescale 1ns/10ps
module pet_timer
   import pet_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire pet_config_t cfg_i,
   input  wire pet_cpu_wr_t cpu_wr_i,
   input  wire logic        event_pin_i,
   input  wire logic        capture_input_pin_i,
   input  wire logic        tooth_edge_input_i,
   output logic             pwm_wave_o,
   output pet_status_t      status_o
);

   typedef struct packed {
      logic [PSC_W-1:0] psc_b;
      logic [PSC_W-1:0] psc_c;
      logic [PSC_W-1:0] psc_d;
      logic [2:0]       st2_pwm;
      logic [2:0]       st2_cap;
      logic [2:0]       st2_tooth;
      logic [CNT_W-1:0] pwm_cnt;
      logic [CNT_W-1:0] cycle;
      logic [CNT_W-1:0] duty;
      logic [CNT_W-1:0] buffer;
      logic             pwm_out;
      logic [2:0]       ev_sync;
      logic             ev_lvl;
      logic [CNT_W-1:0] ev_cnt;
      logic [CNT_W-1:0] ev_cmp;
      logic [2:0]       cap_sync;
      logic             cap_lvl;
      logic [CNT_W-1:0] cap_cnt;
      logic [CNT_W-1:0] cap_val;
      logic [2:0]       th_sync;
      logic             th_lvl;
      logic [CNT_W-1:0] th_interval;
      logic [CNT_W-1:0] th_reload;
      logic [CNT_W-1:0] th_down;
      logic [CNT_W-1:0] th_cnt;
      logic [CNT_W-1:0] th_cmp;
      logic [FLG_W-1:0] flags;
      logic [FLG_W-1:0] irq;
      logic             dma_req;
   } pet_state_t;

   pet_state_t       s;
   pet_state_t       next_s;

   logic             tick_b;
   logic             tick_c;
   logic             tick_d;
   logic             pwm_tick;
   logic             cap_tick;
   logic             th_tick;
   logic             wr;
   logic [CNT_W-1:0] pwm_inc;
   logic [CNT_W-1:0] ev_inc;
   logic [CNT_W-1:0] th_inc;
   logic             cyc_match;
   logic             duty_match;
   logic             ev_edge;
   logic             ev_match;
   logic             cap_edge;
   logic             cap_trigger;
   logic             cap_ovf;
   logic             th_edge;
   logic             th_mult_tick;
   logic             th_match;
   logic [FLG_W-1:0] flag_set;
   logic [FLG_W-1:0] flag_clr;

   // 3'h1 << sel minus one gives the mask of low stage-2 bits that must be zero
   function automatic logic stage2_hit(input logic tick, input logic [2:0] cnt, input pet_div_t sel);
      logic [2:0] mask;
      mask = 3'((STAGE2_ONE << sel) - STAGE2_ONE);
      return tick & ((cnt & mask) == 3'h0);
   endfunction

   function automatic logic edge_hit(input logic old_lvl, input logic new_lvl, input pet_edge_t sel);
      logic rise;
      logic fall;
      rise = ~old_lvl & new_lvl;
      fall = old_lvl & ~new_lvl;
      return (sel[0] & rise) | (sel[1] & fall);
   endfunction

   function automatic logic write_to(input pet_cpu_wr_t w, input pet_target_t t);
      return w.valid & (w.target == t);
   endfunction

   always_comb begin
      next_s = s;
      wr = cpu_wr_i.valid;

      // first stage divides by value+1, second stage by 1/2/4/8 per channel
      // >= so a divisor lowered below the running count restarts at once instead of wrapping through 255
      tick_b = (s.psc_b >= cfg_i.prescaler_stage1_b);
      tick_c = (s.psc_c >= cfg_i.prescaler_stage1_c);
      tick_d = (s.psc_d >= cfg_i.prescaler_stage1_d);
      next_s.psc_b = tick_b ? '0 : PSC_W'(s.psc_b + PSC_ONE); // see [R1]
      next_s.psc_c = tick_c ? '0 : PSC_W'(s.psc_c + PSC_ONE);
      next_s.psc_d = tick_d ? '0 : PSC_W'(s.psc_d + PSC_ONE);
      next_s.st2_pwm = tick_b ? 3'(s.st2_pwm + STAGE2_ONE) : s.st2_pwm;
      next_s.st2_cap = tick_c ? 3'(s.st2_cap + STAGE2_ONE) : s.st2_cap;
      next_s.st2_tooth = tick_d ? 3'(s.st2_tooth + STAGE2_ONE) : s.st2_tooth;
      pwm_tick = cfg_i.counter_start[0] & stage2_hit(tick_b, s.st2_pwm, cfg_i.pwm_clock_select); // see [R1] [R4]
      cap_tick = cfg_i.counter_start[1] & stage2_hit(tick_c, s.st2_cap, cfg_i.capture_clock_select);
      th_tick = cfg_i.counter_start[2] & stage2_hit(tick_d, s.st2_tooth, cfg_i.tooth_clock_select);

      // pin synchronisers: a level change counts once stages two and three agree
      next_s.ev_sync = {s.ev_sync[1:0], event_pin_i};
      next_s.cap_sync = {s.cap_sync[1:0], capture_input_pin_i};
      next_s.th_sync = {s.th_sync[1:0], tooth_edge_input_i};
      if (s.ev_sync[1] == s.ev_sync[2]) begin
         next_s.ev_lvl = s.ev_sync[2];
      end
      if (s.cap_sync[1] == s.cap_sync[2]) begin
         next_s.cap_lvl = s.cap_sync[2];
      end
      if (s.th_sync[1] == s.th_sync[2]) begin
         next_s.th_lvl = s.th_sync[2];
      end
      ev_edge = edge_hit(s.ev_lvl, next_s.ev_lvl, cfg_i.event_edge_select); // see [R10]
      cap_edge = edge_hit(s.cap_lvl, next_s.cap_lvl, cfg_i.capture_io_control); // see [R12]
      th_edge = edge_hit(s.th_lvl, next_s.th_lvl, cfg_i.clock_edge_select);

      // pwm: the match is taken on the tick that would reach the cycle value, so the
      // counter walks 0..cycle-1 and the period is exactly the cycle value
      pwm_inc = CNT_W'(s.pwm_cnt + CNT_ONE);
      cyc_match = pwm_tick & (pwm_inc == s.cycle);
      duty_match = pwm_tick & (pwm_inc == s.duty);
      if (pwm_tick) begin
         next_s.pwm_cnt = cyc_match ? CNT_ZERO : pwm_inc; // see [R24]
      end
      if (cyc_match) begin
         next_s.duty = s.buffer; // see [R5]
         // a zero duty never matches, so the output would otherwise stay high for the whole period
         next_s.pwm_out = (s.buffer != CNT_ZERO); // see [R2] [R7]
      end else if (duty_match) begin
         next_s.pwm_out = 1'b0; // see [R2]
      end
      if (write_to(cpu_wr_i, PET_TGT_PWM_COUNT)) begin
         next_s.pwm_cnt = cpu_wr_i.data; // see [R17] [R18]
      end
      if (write_to(cpu_wr_i, PET_TGT_DUTY)) begin
         next_s.duty = cpu_wr_i.data; // see [R21]
      end
      if (write_to(cpu_wr_i, PET_TGT_CYCLE)) begin
         next_s.cycle = cpu_wr_i.data;
      end
      if (write_to(cpu_wr_i, PET_TGT_BUFFER)) begin
         next_s.buffer = cpu_wr_i.data;
      end

      // event counter runs on pin edges alone, no start bit
      ev_inc = CNT_W'(s.ev_cnt + CNT_ONE);
      ev_match = ev_edge & (ev_inc == s.ev_cmp); // see [R9]
      if (ev_edge) begin
         next_s.ev_cnt = ev_match ? CNT_ZERO : ev_inc;
      end
      if (write_to(cpu_wr_i, PET_TGT_EVENT_COUNT)) begin
         next_s.ev_cnt = cpu_wr_i.data; // see [R18]
      end
      if (write_to(cpu_wr_i, PET_TGT_EVENT_CMP)) begin
         next_s.ev_cmp = cpu_wr_i.data;
      end

      // capture channel; capture happens whether or not its counter runs
      cap_ovf = cap_tick & (s.cap_cnt == CNT_MAX);
      if (cap_tick) begin
         next_s.cap_cnt = CNT_W'(s.cap_cnt + CNT_ONE);
      end
      if (write_to(cpu_wr_i, PET_TGT_CAP_COUNT)) begin
         next_s.cap_cnt = cpu_wr_i.data; // see [R18] [R19]
      end
      cap_trigger = (cfg_i.capture_trigger_enable & ev_match) | cap_edge; // see [R11]
      if (cap_trigger) begin
         next_s.cap_val = s.cap_cnt;
      end

      // missing teeth: interval between edges, scaled down by 2^factor, paces the
      // multiplied counter; a long gap lets that counter reach its compare value
      th_mult_tick = 1'b0;
      if (th_edge) begin
         next_s.th_interval = CNT_ZERO;
         next_s.th_cnt = CNT_ZERO; // see [R15]
         if (cfg_i.reload_update_enable) begin
            next_s.th_reload = CNT_W'(s.th_interval >> cfg_i.edge_multiply_factor); // see [R14]
            next_s.th_down = CNT_W'(s.th_interval >> cfg_i.edge_multiply_factor);
         end else begin
            next_s.th_down = s.th_reload;
         end
      end else if (th_tick) begin
         next_s.th_interval = (s.th_interval == CNT_MAX) ? CNT_MAX : CNT_W'(s.th_interval + CNT_ONE);
         if (s.th_down == CNT_ZERO) begin
            th_mult_tick = 1'b1; // see [R15]
            next_s.th_down = s.th_reload;
         end else begin
            next_s.th_down = CNT_W'(s.th_down - CNT_ONE);
         end
      end
      th_inc = CNT_W'(s.th_cnt + CNT_ONE);
      th_match = th_mult_tick & cfg_i.tooth_compare_mode & (th_inc == s.th_cmp); // see [R16]
      if (th_mult_tick) begin
         next_s.th_cnt = th_inc;
      end
      if (write_to(cpu_wr_i, PET_TGT_TOOTH_RLD)) begin
         next_s.th_reload = cpu_wr_i.data;
      end
      if (write_to(cpu_wr_i, PET_TGT_TOOTH_COUNT)) begin
         next_s.th_cnt = cpu_wr_i.data; // see [R18]
      end
      if (write_to(cpu_wr_i, PET_TGT_TOOTH_CMP)) begin
         next_s.th_cmp = cpu_wr_i.data;
      end

      // flags: a zero written to a bit clears it and beats a set in the same cycle
      flag_set = '0;
      flag_set[FLG_CYCLE] = cyc_match; // see [R3]
      flag_set[FLG_OVF] = cap_ovf; // see [R19]
      flag_set[FLG_EVENT] = ev_match; // see [R9] [R13]
      flag_set[FLG_TOOTH] = th_match;
      flag_clr = write_to(cpu_wr_i, PET_TGT_FLAGS) ? ~cpu_wr_i.data[FLG_W-1:0] : '0;
      next_s.flags = (s.flags | flag_set) & ~flag_clr; // see [R20]
      next_s.irq = next_s.flags & cfg_i.interrupt_enable; // see [R3] [R13]
      next_s.dma_req = cyc_match & cfg_i.dma_enable & ~wr; // see [R3]
      if (cyc_match & cfg_i.dma_enable & wr) begin
         // a cpu write holds the internal bus this cycle; the request still goes out
         next_s.dma_req = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pwm_wave_o = s.pwm_out;
   assign status_o.irq = s.irq;
   assign status_o.dma_req = s.dma_req;
   assign status_o.flags = s.flags;
   assign status_o.pwm_count = s.pwm_cnt;
   assign status_o.duty = s.duty;
   assign status_o.event_count = s.ev_cnt;
   assign status_o.capture_count = s.cap_cnt;
   assign status_o.capture_value = s.cap_val;
   assign status_o.tooth_reload = s.th_reload;
   assign status_o.tooth_count = s.th_cnt;

   property p_pwm_high;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cyc_match && s.buffer != CNT_ZERO) |=> s.pwm_out;
   endproperty
   a_pwm_high: assert property (p_pwm_high) else $error("pwm not high after cycle match"); // see [R2]

   property p_pwm_low;
      @(posedge clk_i) disable iff (sys_rst_i)
      (duty_match && !cyc_match) |=> !s.pwm_out ##1 (s.pwm_out == $past(s.pwm_out) || $past(cyc_match));
   endproperty
   a_pwm_low: assert property (p_pwm_low) else $error("pwm not low after duty match"); // see [R2]

   property p_zero_duty;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cyc_match && s.buffer == CNT_ZERO) |=> !s.pwm_out;
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("zero duty produced a high pulse"); // see [R7]

   property p_buffer_xfer;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cyc_match && !write_to(cpu_wr_i, PET_TGT_DUTY)) |=> (s.duty == $past(s.buffer));
   endproperty
   a_buffer_xfer: assert property (p_buffer_xfer) else $error("buffer not moved into duty"); // see [R5]

   property p_duty_write_wins;
      @(posedge clk_i) disable iff (sys_rst_i)
      write_to(cpu_wr_i, PET_TGT_DUTY) |=> (s.duty == $past(cpu_wr_i.data));
   endproperty
   a_duty_write_wins: assert property (p_duty_write_wins) else $error("duty write lost"); // see [R21]

   property p_restart;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cyc_match && !write_to(cpu_wr_i, PET_TGT_PWM_COUNT)) |=> (s.pwm_cnt == CNT_ZERO);
   endproperty
   a_restart: assert property (p_restart) else $error("pwm counter did not restart"); // see [R24]

   property p_count_write_wins;
      @(posedge clk_i) disable iff (sys_rst_i)
      (pwm_tick && write_to(cpu_wr_i, PET_TGT_PWM_COUNT)) |=> (s.pwm_cnt == $past(cpu_wr_i.data));
   endproperty
   a_count_write_wins: assert property (p_count_write_wins) else $error("counter write lost to count"); // see [R17]

   property p_stopped;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!cfg_i.counter_start[0] && !wr) |=> (s.pwm_cnt == $past(s.pwm_cnt));
   endproperty
   a_stopped: assert property (p_stopped) else $error("pwm counter moved while stopped"); // see [R4]

   property p_ovf_write;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cap_ovf && !write_to(cpu_wr_i, PET_TGT_FLAGS)) |=> s.flags[FLG_OVF] ##1 (s.flags[FLG_OVF] || $past(wr));
   endproperty
   a_ovf_write: assert property (p_ovf_write) else $error("overflow flag not set"); // see [R19]

   property p_clear_wins;
      @(posedge clk_i) disable iff (sys_rst_i)
      (write_to(cpu_wr_i, PET_TGT_FLAGS) && !cpu_wr_i.data[FLG_CYCLE]) |=> !s.flags[FLG_CYCLE] && !s.irq[FLG_CYCLE];
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("flag survived a zero write"); // see [R20]

   property p_cycle_irq;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cyc_match && cfg_i.interrupt_enable[FLG_CYCLE] && !write_to(cpu_wr_i, PET_TGT_FLAGS)) |=> s.irq[FLG_CYCLE];
   endproperty
   a_cycle_irq: assert property (p_cycle_irq) else $error("cycle match raised no interrupt"); // see [R3]

   property p_capture_off;
      @(posedge clk_i) disable iff (sys_rst_i)
      (cfg_i.capture_io_control == PET_EDGE_NONE && !cfg_i.capture_trigger_enable) |=> $stable(s.cap_val);
   endproperty
   a_capture_off: assert property (p_capture_off) else $error("capture taken while disabled"); // see [R12]

   property p_event_capture;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ev_match && cfg_i.capture_trigger_enable) |=> (s.cap_val == $past(s.cap_cnt)) && !$rose(s.irq[FLG_OVF]);
   endproperty
   a_event_capture: assert property (p_event_capture) else $error("event match gave no capture"); // see [R11]

   property p_tooth_clear;
      @(posedge clk_i) disable iff (sys_rst_i)
      (th_edge && !write_to(cpu_wr_i, PET_TGT_TOOTH_COUNT)) |=> (s.th_cnt == CNT_ZERO);
   endproperty
   a_tooth_clear: assert property (p_tooth_clear) else $error("tooth edge did not clear counter"); // see [R15]

endmodule
